// ---- src/spi_guard_pkg.sv ----
// Overview of operation
// - each frame moves a 16-bit command in on serial input, 16-bit response out
// - frame opens on chip_select_n low; clocks ignored while it is high
// - received word is interpreted only after chip_select_n returns high
// - serial output released to high impedance whenever chip_select_n is high
// - serial input shifted into receive register on each falling serial clock edge
// - serial output moves to next response bit after each rising serial clock edge
// - invalid or prohibited command sets sticky failure flag and is discarded, except a sleep request lacking a wake source
// - stop to sleep request is refused, flags failure, requests restart mode
// - stop or sleep request in init mode flags failure, requests normal mode
// - watchdog control write with odd data parity flags failure and is dropped
// - configuration change while in stop mode is dropped and flags failure
// - stop mode accepts only triggers, normal, soft reset, stop, status clears
// - stop entry with wake status set pulses interrupt, failure flag untouched
// - stop to normal ignores other mode bits; io reset field changes flag failure
// - sleep request with no wake source outside init mode flags failure and requests restart
// - sleep request refused for lack of wake source still applies the rest of its data byte
// - stop request with no wake source is accepted without failure outside init mode
// - after first regulator-on write the regulator voltage field stays frozen
// - boost voltage change while boost enabled is dropped and flags failure
// - all-zero or all-one received word is invalid and flags failure
// - word: address bits 6..0, access bit 7, data byte bits 15..8
// - clock count other than 0 or 16 drops word, reports error bit next frame
package spi_guard_pkg;

  // frame layout
  localparam int        FRAME_BITS    = 16;
  localparam int        ADDR_W        = 7;
  localparam int        ACCESS_POS    = 7;
  localparam int        DATA_LSB      = 8;

  // register offsets
  localparam logic [6:0] MODE_CTRL_ADDR   = 7'h01;
  localparam logic [6:0] SUPPLY_CTRL_ADDR = 7'h02;
  localparam logic [6:0] WATCHDOG_ADDR    = 7'h03;
  localparam logic [6:0] BOOST_CTRL_ADDR  = 7'h0a;
  localparam logic [6:0] STATUS_BASE      = 7'h40;
  localparam logic [6:0] DEV_STATUS_ADDR  = 7'h43;

  // field positions inside the data byte
  localparam int        MODE_FIELD_HI = 7;
  localparam int        MODE_FIELD_LO = 6;
  localparam int        IO_OV_RST_POS = 5;
  localparam int        IO_RT_HI      = 4;
  localparam int        IO_RT_LO      = 3;
  localparam int        EXT_ON_POS    = 2;
  localparam int        EXT_VSEL_HI   = 1;
  localparam int        EXT_VSEL_LO   = 0;
  localparam int        BOOST_EN_POS  = 0;
  localparam int        BOOST_V_HI    = 2;
  localparam int        BOOST_V_LO    = 1;
  localparam int        FAIL_CLR_POS  = 3;

  // mode field codes in a command
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_SLEEP  = 2'h1;
  localparam logic [1:0] CMD_STOP   = 2'h2;
  localparam logic [1:0] CMD_RESET  = 2'h3;

  // device mode codes, used for current mode and for requests
  localparam logic [2:0] MODE_INIT    = 3'h0;
  localparam logic [2:0] MODE_NORMAL  = 3'h1;
  localparam logic [2:0] MODE_STOP    = 3'h2;
  localparam logic [2:0] MODE_SLEEP   = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;
  localparam logic [2:0] MODE_SOFTRST = 3'h5;

  // interrupt low time
  localparam int        CLK_PERIOD_NS  = 10;
  localparam int        INT_LOW_NS     = 1000;
  localparam int        INT_LOW_CYCLES = (INT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : spi_guard_pkg

// ---- src/pin_sync3.sv ----
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts once stages two and three agree
module pin_sync3 #(
  parameter int         WIDTH     = 1,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // pins and filtered result
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("pin_sync3: WIDTH must be 1 to 8");
  end

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // ff1 feeds only ff2, so a metastable first stage never reaches logic
  always_comb begin
    next_s     = s;
    next_s.ff1 = i_pin;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.ff2[i] == s.ff3[i]) begin
        next_s.level[i] = s.ff3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= {4{RESET_VAL[WIDTH-1:0]}};
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

endmodule : pin_sync3

// ---- src/spi_slave_command_guard.sv ----
`timescale 1ns/1ps
module spi_slave_command_guard #(
  parameter int FRAME_BITS = spi_guard_pkg::FRAME_BITS
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe_n,
  // response word and device state
  input  wire logic [15:0] i_resp_word,
  input  wire logic [2:0]  i_mode,
  input  wire logic [7:0]  i_mode_ctrl_now,
  input  wire logic [7:0]  i_supply_ctrl_now,
  input  wire logic [7:0]  i_watchdog_now,
  input  wire logic [7:0]  i_boost_ctrl_now,
  input  wire logic        i_no_wake_source,
  input  wire logic [7:0]  i_wake_status_a,
  input  wire logic [7:0]  i_wake_status_b,
  // accepted access towards the register file
  output logic            o_apply,
  output logic [6:0]      o_apply_addr,
  output logic [7:0]      o_apply_data,
  output logic            o_apply_write,
  // mode request towards the mode controller
  output logic            o_mode_req_valid,
  output logic [2:0]      o_mode_req,
  // status
  output logic            o_cmd_fail,
  output logic            o_spi_err,
  output logic            o_interrupt_out_n
);

  localparam int CW = $clog2(FRAME_BITS + 1) + 1;
  localparam int IW = $clog2(spi_guard_pkg::INT_LOW_CYCLES + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(FRAME_BITS);
  localparam logic [CW-1:0] MAX_COUNT  = {CW{1'b1}};
  localparam logic [IW-1:0] INT_LOAD   = IW'(spi_guard_pkg::INT_LOW_CYCLES);

  initial begin
    if (FRAME_BITS != 16) $error("spi_slave_command_guard: frame decode needs 16 bits");
  end

  typedef struct packed {
    logic [15:0]   rx;
    logic [15:0]   tx;
    logic [CW-1:0] cnt;
    logic          active;
    logic          edge_bad;
    logic          err;
    logic          ext_locked;
    logic          fail;
    logic          apply;
    logic [6:0]    apply_addr;
    logic [7:0]    apply_data;
    logic          apply_write;
    logic          mode_req_valid;
    logic [2:0]    mode_req;
    logic [IW-1:0] int_cnt;
    logic          int_n;
    logic          sdo;
    logic          sdo_oe_n;
    logic          sclk_q;
    logic          cs_q;
  } guard_state_t;

  guard_state_t s;
  guard_state_t next_s;

  // pin synchronisers: sclk, chip select, data in
  logic [2:0] pins;

  pin_sync3 #(
    .WIDTH     (3),
    .RESET_VAL (8'h02)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    ({i_sdi, i_chip_select_n, i_sclk}),
    .o_level  (pins)
  );

  logic sclk;
  logic cs_n;
  logic sdi;
  assign sclk = pins[0];
  assign cs_n = pins[1];
  assign sdi  = pins[2];

  // command mode code to device mode request
  function automatic logic [2:0] mode_of(input logic [1:0] code);
    case (code)
      spi_guard_pkg::CMD_NORMAL: mode_of = spi_guard_pkg::MODE_NORMAL;
      spi_guard_pkg::CMD_SLEEP:  mode_of = spi_guard_pkg::MODE_SLEEP;
      spi_guard_pkg::CMD_STOP:   mode_of = spi_guard_pkg::MODE_STOP;
      default:                   mode_of = spi_guard_pkg::MODE_SOFTRST;
    endcase
  endfunction : mode_of

  // frame tracking, shifting and command guarding
  always_comb begin
    logic        cs_fall;
    logic        cs_rise;
    logic        bad;
    logic [15:0] w;
    logic [6:0]  addr;
    logic        acc;
    logic [7:0]  d;
    logic [1:0]  req;
    logic        set_fail;
    logic        clr_fail;
    logic        do_apply;
    logic        in_stop;
    cs_fall  = s.cs_q & ~cs_n;
    cs_rise  = ~s.cs_q & cs_n;
    bad      = 1'b0;
    w        = s.rx;
    addr     = w[spi_guard_pkg::ADDR_W-1:0];
    acc      = w[spi_guard_pkg::ACCESS_POS];
    d        = w[15:spi_guard_pkg::DATA_LSB];
    req      = d[spi_guard_pkg::MODE_FIELD_HI:spi_guard_pkg::MODE_FIELD_LO];
    set_fail = 1'b0;
    clr_fail = 1'b0;
    do_apply = 1'b0;
    in_stop  = (i_mode == spi_guard_pkg::MODE_STOP);

    next_s                = s;
    next_s.sclk_q         = sclk;
    next_s.cs_q           = cs_n;
    next_s.apply          = 1'b0;
    next_s.mode_req_valid = 1'b0;

    // interrupt hold; long enough for a slow port poll to see it
    if (s.int_cnt != '0) begin
      next_s.int_cnt = s.int_cnt - IW'(1);
    end
    next_s.int_n = (next_s.int_cnt == '0);

    if (cs_fall) begin
      // error bit replaces the first response bit, valid before any clock
      next_s.active   = 1'b1;
      next_s.cnt      = '0;
      next_s.edge_bad = sclk;
      next_s.tx       = {i_resp_word[15:1], s.err};
      next_s.sdo      = s.err;
      next_s.sdo_oe_n = 1'b0;
    end else if (s.active && !cs_n) begin
      if (s.sclk_q && !sclk) begin
        next_s.rx = {sdi, s.rx[15:1]};
        if (s.cnt != MAX_COUNT) begin
          next_s.cnt = s.cnt + CW'(1);
        end
      end
      if (!s.sclk_q && sclk) begin
        next_s.tx  = {1'b0, s.tx[15:1]};
        next_s.sdo = s.tx[1];
      end
    end

    if (cs_rise && s.active) begin
      next_s.active   = 1'b0;
      next_s.sdo_oe_n = 1'b1;
      next_s.sdo      = 1'b0;
      bad = s.edge_bad | sclk | ((s.cnt != '0) && (s.cnt != FULL_COUNT));
      next_s.err = bad;
      // interpretation happens only here, after the select is released
      if (!bad && s.cnt == FULL_COUNT &&
          i_mode != spi_guard_pkg::MODE_SLEEP && i_mode != spi_guard_pkg::MODE_RESTART) begin
        if (w == 16'h0000 || w == 16'hffff) begin
          set_fail = 1'b1;
        end else if (!acc) begin
          do_apply = 1'b0;
        end else if (addr >= spi_guard_pkg::STATUS_BASE) begin
          // read-and-clear is legal in every interpreting mode
          do_apply = 1'b1;
          if (addr == spi_guard_pkg::DEV_STATUS_ADDR && d[spi_guard_pkg::FAIL_CLR_POS]) begin
            clr_fail = 1'b1;
          end
        end else if (addr == spi_guard_pkg::MODE_CTRL_ADDR) begin
          next_s.mode_req = mode_of(req);
          next_s.mode_req_valid = 1'b1;
          if (in_stop) begin
            if (req == spi_guard_pkg::CMD_SLEEP) begin
              set_fail        = 1'b1;
              next_s.mode_req = spi_guard_pkg::MODE_RESTART;
            end else if (req == spi_guard_pkg::CMD_NORMAL &&
                         (d[spi_guard_pkg::IO_OV_RST_POS] !=
                          i_mode_ctrl_now[spi_guard_pkg::IO_OV_RST_POS] ||
                          d[spi_guard_pkg::IO_RT_HI:spi_guard_pkg::IO_RT_LO] !=
                          i_mode_ctrl_now[spi_guard_pkg::IO_RT_HI:spi_guard_pkg::IO_RT_LO])) begin
              set_fail = 1'b1;
            end
            // other mode bits stay as they are: no write in stop mode
          end else if (i_mode == spi_guard_pkg::MODE_INIT &&
                       (req == spi_guard_pkg::CMD_STOP || req == spi_guard_pkg::CMD_SLEEP)) begin
            set_fail        = 1'b1;
            next_s.mode_req = spi_guard_pkg::MODE_NORMAL;
          end else if (req == spi_guard_pkg::CMD_SLEEP && i_no_wake_source) begin
            set_fail        = 1'b1;
            next_s.mode_req = spi_guard_pkg::MODE_RESTART;
            do_apply        = 1'b1;
          end else begin
            do_apply = 1'b1;
            if (req == spi_guard_pkg::CMD_STOP &&
                (i_wake_status_a != 8'h00 || i_wake_status_b != 8'h00)) begin
              next_s.int_cnt = INT_LOAD;
              next_s.int_n   = 1'b0;
            end
          end
        end else if (addr == spi_guard_pkg::WATCHDOG_ADDR) begin
          if (^d) begin
            set_fail = 1'b1;
          end else if (in_stop && d != i_watchdog_now) begin
            set_fail = 1'b1;
          end else begin
            do_apply = 1'b1;
          end
        end else if (in_stop) begin
          set_fail = 1'b1;
        end else if (addr == spi_guard_pkg::BOOST_CTRL_ADDR &&
                     i_boost_ctrl_now[spi_guard_pkg::BOOST_EN_POS] &&
                     d[spi_guard_pkg::BOOST_V_HI:spi_guard_pkg::BOOST_V_LO] !=
                     i_boost_ctrl_now[spi_guard_pkg::BOOST_V_HI:spi_guard_pkg::BOOST_V_LO]) begin
          set_fail = 1'b1;
        end else begin
          do_apply = 1'b1;
          if (addr == spi_guard_pkg::SUPPLY_CTRL_ADDR) begin
            if (s.ext_locked) begin
              d[spi_guard_pkg::EXT_VSEL_HI:spi_guard_pkg::EXT_VSEL_LO] =
                i_supply_ctrl_now[spi_guard_pkg::EXT_VSEL_HI:spi_guard_pkg::EXT_VSEL_LO];
            end
            if (d[spi_guard_pkg::EXT_ON_POS]) begin
              next_s.ext_locked = 1'b1;
            end
          end
        end
      end
    end

    // a prohibited command never reaches the register file, except a sleep request refused for lack of wake source
    next_s.apply = do_apply;
    if (do_apply) begin
      next_s.apply_addr  = addr;
      next_s.apply_data  = d;
      next_s.apply_write = acc;
    end
    // set wins over a clear landing in the same cycle
    next_s.fail = (s.fail & ~clr_fail) | set_fail;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s          <= '0;
      s.int_n    <= 1'b1;
      s.sdo_oe_n <= 1'b1;
      s.cs_q     <= 1'b1;
      s.mode_req <= spi_guard_pkg::MODE_INIT;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign o_sdo             = s.sdo;
  assign o_sdo_oe_n        = s.sdo_oe_n;
  assign o_apply           = s.apply;
  assign o_apply_addr      = s.apply_addr;
  assign o_apply_data      = s.apply_data;
  assign o_apply_write     = s.apply_write;
  assign o_mode_req_valid  = s.mode_req_valid;
  assign o_mode_req        = s.mode_req;
  assign o_cmd_fail        = s.fail;
  assign o_spi_err         = s.err;
  assign o_interrupt_out_n = s.int_n;

endmodule : spi_slave_command_guard

// ---- dv/spi_guard_properties.sv ----
`timescale 1ns/1ps
module spi_guard_properties (
  // watched ports
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_sclk,
  input wire logic       i_chip_select_n,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_n,
  input wire logic       o_apply,
  input wire logic       o_mode_req_valid,
  input wire logic [2:0] o_mode_req,
  input wire logic       o_cmd_fail,
  input wire logic       o_interrupt_out_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  int low_cnt;
  // low time counter; a wrong pulse width shows as a wrong count at the rise
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) low_cnt <= 0;
    else low_cnt <= o_interrupt_out_n ? 0 : low_cnt + 1;
  end
  // the pin synchroniser takes about four cycles, so pin levels are looked at 3 back
  a_sdo_released: assert property (i_chip_select_n [*6] |-> o_sdo_oe_n)
    else $error("sdo driven while deselected");
  a_apply_after_cs: assert property (o_apply |-> $past(i_chip_select_n, 3) && o_sdo_oe_n)
    else $error("apply before frame end");
  a_req_after_cs: assert property (o_mode_req_valid |-> $past(i_chip_select_n, 3) && o_sdo_oe_n)
    else $error("mode request before frame end");
  a_apply_one_cycle: assert property (o_apply |=> !o_apply)
    else $error("apply longer than one cycle");
  a_req_one_cycle: assert property (o_mode_req_valid |=> !o_mode_req_valid)
    else $error("mode request longer than one cycle");
  a_fail_at_end: assert property ($changed(o_cmd_fail) |-> o_sdo_oe_n && $past(i_chip_select_n, 3))
    else $error("fail flag moved inside a frame");
  a_sdo_after_rise: assert property (!o_sdo_oe_n && $past(!o_sdo_oe_n) && $changed(o_sdo)
    |-> $past(i_sclk, 3))
    else $error("sdo moved without a rising clock");
  a_int_length: assert property ($rose(o_interrupt_out_n)
    |-> low_cnt == spi_guard_pkg::INT_LOW_CYCLES)
    else $error("interrupt low time wrong");
  a_int_on_stop: assert property ($fell(o_interrupt_out_n)
    |-> o_mode_req_valid && o_mode_req == spi_guard_pkg::MODE_STOP)
    else $error("interrupt without stop request");
  a_int_keeps_fail: assert property ($fell(o_interrupt_out_n) |-> $stable(o_cmd_fail))
    else $error("fail flag moved at stop entry");
endmodule : spi_guard_properties

// ---- dv/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model (
  // clock
  input wire logic i_clk,
  // serial pins towards the device
  output logic     o_sclk,
  output logic     o_chip_select_n,
  output logic     o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_chip_select_n = 1'b1;
    o_sdi = 1'b0;
  end
  // waits n system clocks, then steps off the edge; 8 give half a 160 ns bit
  task automatic half(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : half
  // one frame lsb first on its own select; n other than 0 or 16 makes a broken frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_chip_select_n = 1'b0;
    o_sdi = w[0];
    half(8);
    r[0] = i_sdo;
    for (int i = 0; i < n; i++) begin
      // a seventeenth clock has no response bit left to store, so its sample is dropped
      if (i < 16) r[i] = i_sdo;
      o_sclk = 1'b1;
      half(8);
      o_sclk = 1'b0;
      half(4);
      o_sdi = w[(i + 1) % 16];
      half(4);
    end
    o_chip_select_n = 1'b1; // sclk low at both select edges
    half(8);
  endtask : xfer
endmodule : spi_master_model

// ---- dv/spi_slave_command_guard_bench.sv ----
`timescale 1ns/1ps
module spi_slave_command_guard_bench;
  // pins, state inputs and observed outputs
  logic        clk = 1'b0;
  logic        resetn, sclk, cs_n, sdi, sdo, oe_n, sdo_last, sdo_wire;
  logic [15:0] rsp;
  logic [2:0]  mode, rq, ex_rq;
  logic [7:0]  snow, bnow, wk, adata, ex_data;
  logic [6:0]  aaddr;
  logic        nowake, apply, awrite, rv, fail, err, interrupt_out_n;
  logic        ex_ap, ex_rv, ex_int, ex_fail, ex_err, lock;
  int          mismatches, n_compared, n_ap, n_rv, n_low, cycles;
  int          bad[4] = '{5, 17, 0, 16};

  always #5 clk = ~clk;
  // a released line shows the inverse of its last bit, never a kind constant
  assign sdo_wire = oe_n ? ~sdo_last : sdo;

  spi_slave_command_guard dut_u (.i_clk(clk), .i_resetn(resetn), .i_sclk(sclk),
    .i_chip_select_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(oe_n), .i_resp_word(rsp),
    .i_mode(mode), .i_mode_ctrl_now(8'h00), .i_supply_ctrl_now(snow), .i_watchdog_now(8'h03),
    .i_boost_ctrl_now(bnow), .i_no_wake_source(nowake), .i_wake_status_a(wk),
    .i_wake_status_b(wk), .o_apply(apply), .o_apply_addr(aaddr), .o_apply_data(adata),
    .o_apply_write(awrite), .o_mode_req_valid(rv), .o_mode_req(rq), .o_cmd_fail(fail),
    .o_spi_err(err), .o_interrupt_out_n(interrupt_out_n));
  spi_master_model master_u (.i_clk(clk), .o_sclk(sclk), .o_chip_select_n(cs_n),
    .o_sdi(sdi), .i_sdo(sdo_wire));

  // pulse counters and hang guard
  always @(posedge clk) begin
    if (apply === 1'b1) n_ap <= n_ap + 1;
    if (rv === 1'b1) n_rv <= n_rv + 1;
    if (interrupt_out_n === 1'b0) n_low <= n_low + 1;
    if (oe_n === 1'b0) sdo_last <= sdo;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk

  function automatic logic [15:0] mc(input logic [7:0] d);
    return {d, 1'b1, spi_guard_pkg::MODE_CTRL_ADDR};
  endfunction : mc
  function automatic logic [15:0] wd(input logic [7:0] d);
    return {d, 1'b1, spi_guard_pkg::WATCHDOG_ADDR};
  endfunction : wd
  function automatic logic [15:0] sp(input logic [7:0] d);
    return {d, 1'b1, spi_guard_pkg::SUPPLY_CTRL_ADDR};
  endfunction : sp
  function automatic logic [15:0] bo(input logic [7:0] d);
    return {d, 1'b1, spi_guard_pkg::BOOST_CTRL_ADDR};
  endfunction : bo

  // reference model of one frame's outcome
  task automatic model(input logic [15:0] w, input int n);
    logic [7:0] d;
    logic [1:0] m;
    logic       s;
    logic       nm;
    logic       f;
    d = w[15:8];
    m = d[7:6];
    s = mode == spi_guard_pkg::MODE_STOP;
    nm = !s && mode != spi_guard_pkg::MODE_INIT;
    f = 1'b0;
    ex_ap = 1'b0;
    ex_rv = 1'b0;
    ex_int = 1'b0;
    ex_data = d;
    ex_err = n != 0 && n != 16;
    if (n != 16) return;
    if (w == 16'h0000 || w == 16'hffff) begin
      f = 1'b1;
    end else if (w == mc(d)) begin
      ex_rv = 1'b1;
      ex_ap = nm;
      case (m)
        spi_guard_pkg::CMD_NORMAL: ex_rq = spi_guard_pkg::MODE_NORMAL;
        spi_guard_pkg::CMD_SLEEP: ex_rq = spi_guard_pkg::MODE_SLEEP;
        spi_guard_pkg::CMD_STOP: ex_rq = spi_guard_pkg::MODE_STOP;
        default: ex_rq = spi_guard_pkg::MODE_SOFTRST;
      endcase
      // sleep and stop codes are the two with unequal bits
      if (!nm && !s && m[1] != m[0]) {f, ex_rq} = {1'b1, spi_guard_pkg::MODE_NORMAL};
      if (s && m == spi_guard_pkg::CMD_SLEEP) {f, ex_rq} = {1'b1, spi_guard_pkg::MODE_RESTART};
      if (s && m == spi_guard_pkg::CMD_NORMAL) f = d[5:3] != 3'h0;
      if (nm && m == spi_guard_pkg::CMD_SLEEP && nowake) begin
        {f, ex_rq} = {1'b1, spi_guard_pkg::MODE_RESTART};
      end
      ex_int = nm && m == spi_guard_pkg::CMD_STOP && wk != 8'h00;
    end else if (w == wd(d)) begin
      f = ^d || (s && d != 8'h03);
      ex_ap = !f;
    end else if (w == sp(d)) begin
      f = s;
      ex_ap = !s;
      if (lock) ex_data[1:0] = snow[1:0];
      lock = lock | (ex_ap & d[2]);
    end else if (w == bo(d)) begin
      f = s || (bnow[0] && d[2:1] != bnow[2:1]);
      ex_ap = !f;
    end
    ex_fail = f | (ex_fail & !(w[7:0] == {1'b1, spi_guard_pkg::DEV_STATUS_ADDR} && d[3]));
  endtask : model

  task automatic one(input logic [15:0] w, input int n);
    logic [15:0] r;
    logic [15:0] ex_r;
    logic [15:0] mk;
    logic        ca;
    rsp = 16'($urandom);
    n_ap = 0;
    n_rv = 0;
    n_low = 0;
    ex_r = {rsp[15:1], ex_err};
    ca = w[6:0] != spi_guard_pkg::DEV_STATUS_ADDR;
    // a short frame carries as many response bits as it has clocks, and one if it has none
    mk = (n >= 16) ? 16'hffff : 16'((32'h1 << ((n == 0) ? 1 : n)) - 32'h1);
    master_u.xfer(w, n, r);
    model(w, n);
    repeat (130) @(posedge clk);
    #1;
    chk(r & mk, ex_r & mk, "response");
    if (ca) chk(16'(n_ap), {15'h0, ex_ap}, "apply");
    if (ex_ap) chk({aaddr, adata, awrite}, {w[6:0], ex_data, 1'b1}, "fields");
    chk(16'(n_rv), {15'h0, ex_rv}, "request");
    if (ex_rv) chk({13'h0, rq}, {13'h0, ex_rq}, "request code");
    chk({14'h0, fail, err}, {14'h0, ex_fail, ex_err}, "flags");
    chk(16'(n_low), ex_int ? 16'(spi_guard_pkg::INT_LOW_CYCLES) : 16'h0, "interrupt");
    chk({15'h0, oe_n}, 16'h0001, "release");
    if (ex_ap && !ca) snow = ex_data;
    if (ex_ap && w[6:0] == spi_guard_pkg::SUPPLY_CTRL_ADDR) snow = ex_data;
    $display("test done: word %h clocks %0d", w, n);
  endtask : one

  // a failing command is followed by a clearing write so the next failure shows
  task automatic run(input logic [15:0] w);
    one(w, 16);
    if (ex_fail) one({8'h08, 1'b1, spi_guard_pkg::DEV_STATUS_ADDR}, 16);
  endtask : run

  initial begin
    resetn = 1'b0;
    rsp = 16'h0000;
    mode = spi_guard_pkg::MODE_NORMAL;
    {snow, bnow, wk, nowake, sdo_last} = '0;
    {ex_fail, ex_err, lock, mismatches, n_compared, n_ap, n_rv, n_low, cycles} = '0;
    void'($urandom(30379));
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    run(mc(8'h00));
    repeat (4) run({8'($urandom), 1'b0, 7'($urandom) | 7'h01});
    run(16'h0000);
    run(16'hffff);
    foreach (bad[i]) one(mc(8'h00), bad[i]);
    mode = spi_guard_pkg::MODE_INIT;
    run(mc(8'h80));
    run(mc(8'h40));
    mode = spi_guard_pkg::MODE_STOP;
    run(mc(8'h40));
    run(mc(8'h08));
    run(mc(8'h04));
    run(mc(8'h80));
    run(mc(8'hc0));
    run(wd(8'h03));
    run(wd(8'h05));
    run(sp(8'h01));
    run(bo(8'h00));
    mode = spi_guard_pkg::MODE_NORMAL;
    run(wd(8'h01));
    run(wd(8'h06));
    nowake = 1'b1;
    run(mc(8'h44));
    run(mc(8'h80));
    nowake = 1'b0;
    wk = 8'h01;
    run(mc(8'h80));
    wk = 8'h00;
    run(mc(8'h44));
    run(sp(8'h05));
    run(sp(8'h06));
    bnow = 8'h01;
    run(bo(8'h03));
    run(bo(8'h01));
    bnow = 8'h00;
    run(bo(8'h02));
    summarize();
  end
endmodule : spi_slave_command_guard_bench

bind spi_slave_command_guard spi_guard_properties chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_sclk(i_sclk), .i_chip_select_n(i_chip_select_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
  .o_apply(o_apply), .o_mode_req_valid(o_mode_req_valid), .o_mode_req(o_mode_req),
  .o_cmd_fail(o_cmd_fail), .o_interrupt_out_n(o_interrupt_out_n));
